//--- micctl_slave.sv
// Write-only two-wire control slave for the microphone amplifier.
// Assumes SCL and SDA are asynchronous and slow against CLK_IN.
//
// Behaviour
// - Slave only; master clocks at about 198 kHz
// - SDA stable while SCL high; sample rising
// - START begins address watch
// - STOP returns slave to idle
// - Seven-bit address 1100111, MSB first
// - Reads ignored, never acknowledged
// - Acknowledge matching address on ninth clock
// - Acknowledge every data byte
// - Data bit 7 selects target register
// - Mute bits per microphone, reset 00
// - Enable bits per microphone, reset 00
// - Mode field selects cancel or pass-through
// - Smoothing filter only in cancel mode
// - Chip enable low forces shutdown
// - Power-on reset loads register defaults
`timescale 1ns/1ps
module micctl_slave (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // Chip enable pin
   input wire logic CHIP_EN_IN,
   // Link
   micctl_if.slave LINK,
   // Decoded controls
   output logic [3:0] PRE_GAIN_OUT,
   output logic [2:0] POST_GAIN_OUT,
   output logic [5:0] PRE_GAIN_DB_OUT,
   output logic [4:0] POST_GAIN_DB_OUT,
   output logic MIC1_MUTE_OUT,
   output logic MIC2_MUTE_OUT,
   output logic MIC1_EN_OUT,
   output logic MIC2_EN_OUT,
   output logic [1:0] MODE_OUT,
   output logic SMOOTH_FILTER_EN_OUT,
   output logic SHUTDOWN_OUT,
   output logic BYTE_DONE_OUT
);
   typedef enum logic [2:0] {
      MICS_IDLE,
      MICS_ADDR,
      MICS_ADDR_ACK,
      MICS_DATA,
      MICS_DATA_ACK,
      MICS_IGNORE
   } micctl_state_t;

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [2:0] en_s;
      logic scl_f;
      logic sda_f;
      micctl_state_t st;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic sda_low;
      logic [6:0] gain;
      logic [6:0] mic;
      logic [3:0] pre_out;
      logic [2:0] post_out;
      logic [5:0] pre_db;
      logic [4:0] post_db;
      logic [5:0] micbits;
      logic smooth;
      logic shut;
      logic done;
   } micctl_slave_t;

   micctl_slave_t q;
   micctl_slave_t d;

   function automatic logic [4:0] micctl_post_db(input logic [2:0] code);
      logic [2:0] c;
      c = (code > micctl_pkg::POST_CODE_MAX) ? micctl_pkg::POST_CODE_MAX : code;
      micctl_post_db = 5'h06 + 5'(c) * 5'h03;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic en;
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      en = 1'b0;
      d = q;
      d.scl_s = {q.scl_s[1:0], LINK.scl};
      d.sda_s = {q.sda_s[1:0], LINK.sda};
      d.en_s = {q.en_s[1:0], CHIP_EN_IN};
      d.done = 1'b0;
      // Filtered levels change when stages two and three agree
      if (q.scl_s[1] == q.scl_s[2]) begin
         d.scl_f = q.scl_s[2];
      end
      if (q.sda_s[1] == q.sda_s[2]) begin
         d.sda_f = q.sda_s[2];
      end
      scl_rise = d.scl_f & ~q.scl_f;
      scl_fall = ~d.scl_f & q.scl_f;
      start_c = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f;
      stop_c = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f;
      en = (q.en_s[1] == q.en_s[2]) ? q.en_s[2] : ~q.shut;
      d.shut = ~en;
      if (!en) begin
         d.st = MICS_IDLE;
         d.sda_low = 1'b0;
      end else if (start_c) begin
         d.st = MICS_ADDR;
         d.bit_cnt = 4'h0;
         d.sda_low = 1'b0;
      end else if (stop_c) begin
         d.st = MICS_IDLE;
         d.sda_low = 1'b0;
      end else begin
         case (q.st)
            MICS_ADDR, MICS_DATA: begin
               if (scl_rise) begin
                  d.shift = {q.shift[6:0], q.sda_f};
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end
               if (scl_fall && q.bit_cnt == 4'(micctl_pkg::BYTE_BITS)) begin
                  d.bit_cnt = 4'h0;
                  if (q.st == MICS_ADDR) begin
                     // Match address and write direction only
                     if (q.shift[7:1] == micctl_pkg::SLAVE_ADDR && !q.shift[0]) begin
                        d.st = MICS_ADDR_ACK;
                        d.sda_low = 1'b1;
                     end else begin
                        d.st = MICS_IGNORE;
                     end
                  end else begin
                     d.st = MICS_DATA_ACK;
                     d.sda_low = 1'b1;
                     d.done = 1'b1;
                     if (q.shift[micctl_pkg::SEL_BIT]) begin
                        d.mic = q.shift[6:0];
                     end else begin
                        d.gain = q.shift[6:0];
                     end
                  end
               end
            end
            MICS_ADDR_ACK, MICS_DATA_ACK: begin
               // Release after the ninth clock falls
               if (scl_fall) begin
                  d.sda_low = 1'b0;
                  d.st = MICS_DATA;
               end
            end
            default: begin
               d.sda_low = 1'b0;
            end
         endcase
      end
      // Decoded outputs; microphone bits and filter forced quiet in shutdown, gains kept
      d.pre_out = d.gain[micctl_pkg::PRE_LSB +: micctl_pkg::PRE_W];
      d.post_out = d.gain[micctl_pkg::POST_LSB +: micctl_pkg::POST_W];
      d.pre_db = 6'h06 + {1'b0, d.pre_out, 1'b0};
      d.post_db = micctl_post_db(d.post_out);
      d.micbits = d.shut ? 6'h00 : d.mic[5:0];
      d.smooth = ~d.shut && d.mic[micctl_pkg::MODE_LSB +: micctl_pkg::MODE_W]
         == micctl_pkg::MODE_NOISE_CANCEL;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         q <= '{scl_s: 3'h7, sda_s: 3'h7, en_s: 3'h0, scl_f: 1'b1, sda_f: 1'b1, st: MICS_IDLE,
                bit_cnt: 4'h0, shift: 8'h00, sda_low: 1'b0, gain: micctl_pkg::GAIN_RESET,
                mic: micctl_pkg::MIC_RESET, pre_out: 4'h0, post_out: 3'h0, pre_db: 6'h06,
                post_db: 5'h06, micbits: 6'h00, smooth: 1'b0, shut: 1'b1, done: 1'b0};
      end else begin
         q <= d;
      end
   end

   // Open-drain: drive only low, and never the clock
   assign LINK.sda_s_o = 1'b0;
   assign LINK.sda_s_oe = q.sda_low;
   assign PRE_GAIN_OUT = q.pre_out;
   assign POST_GAIN_OUT = q.post_out;
   assign PRE_GAIN_DB_OUT = q.pre_db;
   assign POST_GAIN_DB_OUT = q.post_db;
   assign MIC1_MUTE_OUT = q.micbits[micctl_pkg::MUTE1_BIT];
   assign MIC2_MUTE_OUT = q.micbits[micctl_pkg::MUTE2_BIT];
   assign MIC1_EN_OUT = q.micbits[micctl_pkg::EN1_BIT];
   assign MIC2_EN_OUT = q.micbits[micctl_pkg::EN2_BIT];
   assign MODE_OUT = q.micbits[micctl_pkg::MODE_LSB +: micctl_pkg::MODE_W];
   assign SMOOTH_FILTER_EN_OUT = q.smooth;
   assign SHUTDOWN_OUT = q.shut;
   assign BYTE_DONE_OUT = q.done;
endmodule

//--- micctl_pkg.sv
// Shared constants for the microphone amplifier control link.
// Assumes both ends are compiled after this package.
package micctl_pkg;
   // ----------------------------------------
   // Bus address and framing
   // ----------------------------------------
   localparam logic [6:0] SLAVE_ADDR = 7'h67;
   localparam int BYTE_BITS = 8;
   // ----------------------------------------
   // Register selector and fields
   // ----------------------------------------
   localparam int SEL_BIT = 7;
   localparam int PRE_LSB = 0;
   localparam int PRE_W = 4;
   localparam int POST_LSB = 4;
   localparam int POST_W = 3;
   localparam int MUTE1_BIT = 0;
   localparam int MUTE2_BIT = 1;
   localparam int EN1_BIT = 2;
   localparam int EN2_BIT = 3;
   localparam int MODE_LSB = 4;
   localparam int MODE_W = 2;
   localparam logic [6:0] GAIN_RESET = 7'h00;
   localparam logic [6:0] MIC_RESET = 7'h00;
   localparam logic [1:0] MODE_NOISE_CANCEL = 2'h0;
   localparam logic [1:0] MODE_PASS_MIC1 = 2'h1;
   localparam logic [1:0] MODE_PASS_MIC2 = 2'h2;
   localparam logic [2:0] POST_CODE_MAX = 3'h4;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 50000000;
   localparam int SCL_MAX_HZ = 400000;
   // Quarter period of the generated serial clock (one master step), rounded up so the rate never exceeds the limit
   localparam int SCL_HALF_CYC = (CLK_HZ + 2 * SCL_MAX_HZ - 1) / (2 * SCL_MAX_HZ);
   localparam int POR_RAMP_MS = 100;
endpackage

//--- micctl_if.sv
// Two-wire link between the bus master and the amplifier control slave.
// Assumes open-drain wiring with pull-ups resolved here.
`timescale 1ns/1ps
interface micctl_if;
   logic scl_o;
   logic scl_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // Pulled high unless some end drives low
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
   modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
   modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface

//--- micctl_master.sv
// Bus master that writes one control byte per request to the amplifier.
// Assumes the user holds a request until it is accepted.
`timescale 1ns/1ps
module micctl_master #(
   parameter int HALF_CYC = micctl_pkg::SCL_HALF_CYC
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // User request
   input wire logic REQ_IN,
   input wire logic READ_IN,
   input wire logic [7:0] DATA_IN,
   output logic BUSY_OUT,
   output logic DONE_OUT,
   output logic NACK_OUT,
   // Link
   micctl_if.master LINK
);
   typedef enum logic [2:0] {
      MICM_IDLE,
      MICM_START,
      MICM_BITS,
      MICM_STOP,
      MICM_END
   } micctl_mstate_t;

   typedef struct packed {
      micctl_mstate_t st;
      logic [15:0] tick;
      logic [1:0] phase;
      logic [4:0] bit_cnt;
      logic [17:0] frame;
      logic scl;
      logic sda;
      logic [2:0] sda_s;
      logic sda_f;
      logic nack;
      logic busy;
      logic done;
   } micctl_master_t;

   micctl_master_t q;
   micctl_master_t d;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic step;
      step = (q.tick == 16'(HALF_CYC - 1));
      d = q;
      d.done = 1'b0;
      d.tick = step ? 16'h0000 : q.tick + 16'h0001;
      if (q.st == MICM_IDLE) begin
         d.tick = 16'h0000;
      end
      // Data pin passes three flops; a level counts once stages two and three agree
      d.sda_s = {q.sda_s[1:0], LINK.sda};
      if (q.sda_s[1] == q.sda_s[2]) begin
         d.sda_f = q.sda_s[2];
      end
      case (q.st)
         MICM_IDLE: begin
            if (REQ_IN) begin
               // Address, direction, ack slot, data, ack slot
               d.frame = {micctl_pkg::SLAVE_ADDR, READ_IN, 1'b1, DATA_IN, 1'b1};
               d.st = MICM_START;
               d.busy = 1'b1;
               d.nack = 1'b0;
            end
         end
         MICM_START: begin
            if (step) begin
               d.sda = 1'b0;
               d.st = MICM_BITS;
               d.bit_cnt = 5'h00;
               d.phase = 2'h0;
            end
         end
         MICM_BITS: begin
            if (step) begin
               d.phase = q.phase + 2'h1;
               case (q.phase)
                  2'h0: d.scl = 1'b0;
                  2'h1: d.sda = q.frame[17];
                  2'h2: d.scl = 1'b1;
                  default: begin
                     // Ack slots are released high; a high reading is a refusal
                     if ((q.bit_cnt == 5'd8 || q.bit_cnt == 5'd17) && q.sda_f) begin
                        d.nack = 1'b1;
                     end
                     d.frame = {q.frame[16:0], 1'b1};
                     d.bit_cnt = q.bit_cnt + 5'h01;
                     if (q.bit_cnt == 5'd17 || (q.bit_cnt == 5'd8 && q.sda_f)) begin
                        d.st = MICM_STOP;
                     end
                  end
               endcase
            end
         end
         MICM_STOP: begin
            if (step) begin
               d.phase = q.phase + 2'h1;
               case (q.phase)
                  2'h0: d.scl = 1'b0;
                  2'h1: d.sda = 1'b0;
                  2'h2: d.scl = 1'b1;
                  default: begin
                     d.sda = 1'b1;
                     d.st = MICM_END;
                  end
               endcase
            end
         end
         default: begin
            if (step) begin
               d.st = MICM_IDLE;
               d.busy = 1'b0;
               d.done = 1'b1;
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         q <= '{st: MICM_IDLE, tick: 16'h0000, phase: 2'h0, bit_cnt: 5'h00, frame: 18'h3FFFF,
                scl: 1'b1, sda: 1'b1, sda_s: 3'h7, sda_f: 1'b1, nack: 1'b0, busy: 1'b0, done: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign LINK.scl_o = 1'b0;
   assign LINK.scl_oe = ~q.scl;
   assign LINK.sda_m_o = 1'b0;
   assign LINK.sda_m_oe = ~q.sda;
   assign BUSY_OUT = q.busy;
   assign DONE_OUT = q.done;
   assign NACK_OUT = q.nack;
endmodule

//--- micctl_asserts.sv
// Link checks between master and slave ends.
// Assumes tb instantiates it beside the interface.
`timescale 1ns/1ps
module micctl_asserts #(
   parameter int HALF_CYC = micctl_pkg::SCL_HALF_CYC
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // Link
   input wire logic sda_m_o,
   input wire logic sda_m_oe,
   input wire logic sda_s_o,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda
);
   // ----
   // Frame tracking
   // ----
   logic scl_q, sda_q, match_q;
   logic [3:0] bit_q;
   logic [1:0] byte_q;
   logic [7:0] sh_q, hi_q;
   wire rise = scl & ~scl_q;
   wire start = scl & scl_q & sda_q & ~sda;
   wire stp = scl & scl_q & ~sda_q & sda;
   wire slow = sda_s_oe & ~sda_s_o;
   wire ack9 = rise & (bit_q == 4'h8);
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         match_q <= 1'b0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         sh_q <= 8'h00;
         hi_q <= 8'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         hi_q <= !scl ? 8'h00 : (hi_q == 8'hFF) ? hi_q : hi_q + 8'h01;
         if (start) begin
            bit_q <= 4'h0;
            byte_q <= 2'h0;
         end else if (rise) begin
            sh_q <= {sh_q[6:0], sda};
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == 4'h8 && byte_q != 2'h3) begin
               byte_q <= byte_q + 2'h1;
            end
            if (ack9 && byte_q == 2'h0) begin
               match_q <= (sh_q == {micctl_pkg::SLAVE_ADDR, 1'b0});
            end
         end
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);
   chk_scl_high_len: assert property ($fell(scl) |-> hi_q >= HALF_CYC)
      else $error("serial clock high phase too short");
   chk_sda_hold_high: assert property (scl && scl_q |-> $stable(slow))
      else $error("slave changed data while clock high");
   chk_start_free: assert property (start |-> !slow)
      else $error("slave pulled data at start");
   chk_stop_idle: assert property (stp |-> !slow [*8])
      else $error("slave drives after stop");
   chk_addr_ack: assert property (ack9 && byte_q == 2'h0
      |-> slow == (sh_q == {micctl_pkg::SLAVE_ADDR, 1'b0}))
      else $error("address acknowledge wrong");
   chk_ack_slot_only: assert property (rise && slow |-> bit_q == 4'h8)
      else $error("slave drives outside acknowledge slot");
   chk_ack_release: assert property ($fell(scl) && slow |-> ##[1:8] !slow)
      else $error("acknowledge not released");
   chk_data_ack: assert property (ack9 && byte_q != 2'h0 && match_q |-> slow)
      else $error("data byte not acknowledged");
   chk_master_free: assert property (ack9 |-> !(sda_m_oe && !sda_m_o))
      else $error("master holds data in acknowledge slot");
endmodule

//--- tb.sv
// Self-checking bench joining master and slave over the link.
// Assumes package, interface and both ends compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("wrong value %s exp %0h got %0h", n, e, g); \
   end \
end
module tb;
   localparam int HC = 8;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic en = 1'b1;
   logic req = 1'b0;
   logic rd = 1'b0;
   logic [7:0] dat = 8'h00;
   logic [15:0] rnd = 16'h395B;
   logic busy, done, nack, bdone, mute1, mute2, en1, en2, filt, shd;
   logic [3:0] pre;
   logic [2:0] post;
   logic [5:0] predb;
   logic [4:0] postdb;
   logic [1:0] mode;
   int errors = 0;
   int num_checks = 0;
   int pulses = 0;
   int cyc = 0;
   int mg, mm, men;
   logic [7:0] wb;
   logic [6:0] seen;
   logic [7:0] exp_q[$];
   // ----
   // Ends and checker
   // ----
   micctl_if lnk();
   micctl_master #(.HALF_CYC(HC)) i_micctl_master (.CLK_IN(clk), .NRST_IN(nrst), .REQ_IN(req),
      .READ_IN(rd), .DATA_IN(dat), .BUSY_OUT(busy), .DONE_OUT(done), .NACK_OUT(nack), .LINK(lnk.master));
   micctl_slave i_micctl_slave (.CLK_IN(clk), .NRST_IN(nrst), .CHIP_EN_IN(en), .LINK(lnk.slave),
      .PRE_GAIN_OUT(pre), .POST_GAIN_OUT(post), .PRE_GAIN_DB_OUT(predb), .POST_GAIN_DB_OUT(postdb),
      .MIC1_MUTE_OUT(mute1), .MIC2_MUTE_OUT(mute2), .MIC1_EN_OUT(en1), .MIC2_EN_OUT(en2),
      .MODE_OUT(mode), .SMOOTH_FILTER_EN_OUT(filt), .SHUTDOWN_OUT(shd), .BYTE_DONE_OUT(bdone));
   micctl_asserts #(.HALF_CYC(HC)) i_micctl_asserts (.CLK_IN(clk), .NRST_IN(nrst), .sda_m_o(lnk.sda_m_o),
      .sda_m_oe(lnk.sda_m_oe), .sda_s_o(lnk.sda_s_o), .sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl), .sda(lnk.sda));
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (bdone === 1'b1) begin
         pulses++;
         `CHK("queued", 1'b1, exp_q.size() > 0)
         if (exp_q.size() > 0) begin
            wb = exp_q.pop_front();
            seen = wb[7] ? {1'b0, mode, en2, en1, mute2, mute1} : {post, pre};
            `CHK("stored", wb[7] ? {1'b0, wb[5:0]} : wb[6:0], seen)
         end
      end
      if (cyc == 60000) begin
         errors++;
         test_done();
      end
   end
   // ----
   // Tasks
   // ----
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task test_done();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task check_outs();
      `CHK("gain", mg, {post, pre})
      `CHK("pre_db", 6 + 2 * (mg % 16), predb)
      `CHK("post_db", 6 + 3 * ((mg / 16 > 4) ? 4 : mg / 16), postdb)
      `CHK("mic", men ? mm % 64 : 0, {mode, en2, en1, mute2, mute1})
      `CHK("filter", men && mm / 16 % 4 == 0, filt)
      `CHK("shutdown", !men, shd)
   endtask
   task send(input logic r, input logic [7:0] d);
      int p;
      int n;
      p = pulses;
      n = 0;
      if (!r) exp_q.push_back(d);
      req <= 1'b1;
      rd <= r;
      dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b1 && n < 50);
      req <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 2000);
      `CHK("done", 1'b1, done)
      `CHK("nack", r, nack)
      if (!r && d[7]) mm = d[6:0];
      if (!r && !d[7]) mg = d[6:0];
      @(posedge clk);
      `CHK("pulses", r ? 0 : 1, pulses - p)
      check_outs();
   endtask
   task do_reset();
      nrst <= 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      mg = 0;
      mm = 0;
      repeat (8) @(posedge clk);
      check_outs();
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      men = 1;
      do_reset();
      for (int i = 0; i < 8; i++) send(1'b0, {1'b0, i[2:0], i[2:0], i[0]});
      for (int i = 0; i < 4; i++) send(1'b0, {2'b10, i[1:0], 4'(i * 5)});
      send(1'b1, 8'h5A);
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         send(rnd[8] & rnd[3], rnd[7:0]);
      end
      en <= 1'b0;
      men = 0;
      repeat (8) @(posedge clk);
      check_outs();
      en <= 1'b1;
      men = 1;
      repeat (8) @(posedge clk);
      check_outs();
      send(1'b0, 8'h8F);
      do_reset();
      test_done();
   end
endmodule
